/* hdl/fcr_core.v */
`timescale 1ns/1ps
`include "fcr_regs.vh"

module fcr_core #(
    parameter [`FCR_TMR_WIDTH-1:0] PLL_CYCLES = `FCR_PLL_CYCLES
)(
    input wire clk_sys,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire primary_osc_ok,
    input wire clock_fail,
    input wire pll_mode,
    input wire sleep_exec,
    input wire wake_irq,
    output reg [1:0] clk_sel,
    output reg failsafe_active,
    output reg monitor_enable,
    output reg pm_active,
    output wire cpu_run,
    output wire irq
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    reg prim_meta;
    reg prim_sync;
    reg fail_meta;
    reg fail_sync;
    reg fail_prev;
    reg start_wait;
    reg primary_clock_running_flag;
    reg [7:0] osc_ctrl_pend;
    reg [`FCR_EV_WIDTH-1:0] status;
    reg [`FCR_EV_WIDTH-1:0] int_en;
    reg [`FCR_EV_WIDTH-1:0] next_status;
    reg [31:0] next_prdata;
    wire [7:0] oscillator_control_reg;
    wire tmr_done;
    wire fail_event;
    wire wr_access;
    wire rd_setup;
    wire pm_idle;
    wire fail_irq_on;

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    // decode of mapped offsets
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `FCR_OFS_OSC_CTRL) || (a == `FCR_OFS_STATUS) ||
                     (a == `FCR_OFS_INT_EN) || (a == `FCR_OFS_INT_CLR) ||
                     (a == `FCR_OFS_STATE);
        end
    endfunction

    // source code from control reg select field
    function [1:0] src_of;
        input [7:0] r;
        begin
            case (r[`FCR_OSC_SCS_MSB:`FCR_OSC_SCS_LSB])
                2'h0: src_of = `FCR_SRC_PRIMARY;
                2'h1: src_of = `FCR_SRC_SECONDARY;
                default: src_of = `FCR_SRC_INTERNAL;
            endcase
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // two flops on each asynchronous pin
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prim_meta <= 1'b0;
            prim_sync <= 1'b0;
            fail_meta <= 1'b0;
            fail_sync <= 1'b0;
            fail_prev <= 1'b0;
        end
        else
        begin
            prim_meta <= primary_osc_ok;
            prim_sync <= prim_meta;
            fail_meta <= clock_fail;
            fail_sync <= fail_meta;
            fail_prev <= fail_sync;
        end
    end

    // a failure counts only while the monitor is watching
    assign fail_event = fail_sync && !fail_prev && monitor_enable;

    // ----------------------------------------
    // start-up timer
    // ----------------------------------------
    fcr_startup_timer #(
        .PLL_CYCLES(PLL_CYCLES)
    ) u_tmr (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .run(start_wait),
        .osc_ok(prim_sync),
        .pll_mode(pll_mode),
        .done(tmr_done)
    );

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign wr_access = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;

    // ----------------------------------------
    // oscillator control register
    // ----------------------------------------
    // visible value stays at reset while waiting for the primary
    assign oscillator_control_reg = start_wait ? `FCR_OSC_CTRL_RST :
        {osc_ctrl_pend[7:4], primary_clock_running_flag, osc_ctrl_pend[2:0]};

    assign pm_idle = oscillator_control_reg[`FCR_OSC_IDLE_BIT];
    assign fail_irq_on = int_en[`FCR_EV_OSC_FAIL];

    // software write, applied on the next sleep
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            osc_ctrl_pend <= `FCR_OSC_CTRL_RST;
        else if (wr_access && paddr == `FCR_OFS_OSC_CTRL)
            osc_ctrl_pend <= pwdata[7:0] & 8'h83;
    end

    // ----------------------------------------
    // clock switching control
    // ----------------------------------------
    // reset clears failsafe and starts on the internal mux while waiting for the primary
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            clk_sel <= `FCR_SRC_INTERNAL;
            failsafe_active <= 1'b0;
            monitor_enable <= 1'b0;
            pm_active <= 1'b0;
            start_wait <= 1'b1;
            primary_clock_running_flag <= 1'b0;
        end
        else if (fail_event)
        begin
            // failover to the internal mux
            failsafe_active <= 1'b1;
            clk_sel <= `FCR_SRC_INTERNAL;
            primary_clock_running_flag <= 1'b0;
            start_wait <= 1'b0;
            if (pm_active && fail_irq_on)
                pm_active <= 1'b0;
        end
        else if (sleep_exec)
        begin
            // power managed entry clears failsafe, picks source
            failsafe_active <= 1'b0;
            pm_active <= 1'b1;
            start_wait <= 1'b0;
            clk_sel <= src_of(osc_ctrl_pend);
            monitor_enable <= 1'b1;
            primary_clock_running_flag <= (src_of(osc_ctrl_pend) == `FCR_SRC_PRIMARY) && prim_sync;
        end
        else if (start_wait && tmr_done && !failsafe_active)
        begin
            // primary is stable: switch and report
            clk_sel <= `FCR_SRC_PRIMARY;
            primary_clock_running_flag <= 1'b1;
            monitor_enable <= 1'b1;
            start_wait <= 1'b0;
        end
        else if (pm_active && wake_irq)
        begin
            // wake keeps the source; mux stays while failsafe holds
            pm_active <= 1'b0;
        end
    end

    // cpu halts only in an idle power managed mode
    assign cpu_run = !(pm_active && pm_idle);

    // ----------------------------------------
    // event status, set wins over clear
    // ----------------------------------------
    always @*
    begin
        next_status = status;
        if (wr_access && paddr == `FCR_OFS_INT_CLR)
            next_status = status & ~pwdata[`FCR_EV_WIDTH-1:0];
        if (fail_event)
            next_status[`FCR_EV_OSC_FAIL] = 1'b1;
        if (start_wait && tmr_done && !failsafe_active && !sleep_exec)
            next_status[`FCR_EV_PRI_READY] = 1'b1;
        if (pm_active && ((fail_event && fail_irq_on) || (wake_irq && !sleep_exec && !fail_event)))
            next_status[`FCR_EV_PM_EXIT] = 1'b1;
    end

    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            status <= `FCR_EV_RST;
            int_en <= `FCR_EV_RST;
        end
        else
        begin
            status <= next_status;
            if (wr_access && paddr == `FCR_OFS_INT_EN)
                int_en <= pwdata[`FCR_EV_WIDTH-1:0];
        end
    end

    assign irq = |(status & int_en);

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // captured in setup, valid through the access cycle
    always @*
    begin
        next_prdata = 32'h00000000;
        case (paddr)
            `FCR_OFS_OSC_CTRL: next_prdata[7:0] = oscillator_control_reg;
            `FCR_OFS_STATUS: next_prdata[`FCR_EV_WIDTH-1:0] = status;
            `FCR_OFS_INT_EN: next_prdata[`FCR_EV_WIDTH-1:0] = int_en;
            `FCR_OFS_STATE: next_prdata[5:0] = {cpu_run, pm_active, monitor_enable,
                                                failsafe_active, clk_sel};
            default: next_prdata = 32'h00000000;
        endcase
    end

    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            prdata <= 32'h00000000;
        else if (rd_setup)
            prdata <= next_prdata;
    end

endmodule

/* pkg/fcr_regs.vh */
`ifndef FCR_REGS_VH
`define FCR_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FCR_OFS_OSC_CTRL 8'h00
`define FCR_OFS_STATUS 8'h04
`define FCR_OFS_INT_EN 8'h08
`define FCR_OFS_INT_CLR 8'h0C
`define FCR_OFS_STATE 8'h10

// ----------------------------------------
// oscillator_control_reg fields
// ----------------------------------------
`define FCR_OSC_SCS_LSB 0
`define FCR_OSC_SCS_MSB 1
`define FCR_OSC_RUNNING_BIT 3
`define FCR_OSC_IDLE_BIT 7
`define FCR_OSC_CTRL_RST 8'h00

// ----------------------------------------
// clock source codes
// ----------------------------------------
`define FCR_SRC_PRIMARY 2'h0
`define FCR_SRC_SECONDARY 2'h1
`define FCR_SRC_INTERNAL 2'h2

// ----------------------------------------
// event bits of status, enable and clear
// ----------------------------------------
`define FCR_EV_OSC_FAIL 0
`define FCR_EV_PRI_READY 1
`define FCR_EV_PM_EXIT 2
`define FCR_EV_WIDTH 3
`define FCR_EV_RST 3'h0

// ----------------------------------------
// start-up timing
// ----------------------------------------
// counts at the 10 ns system clock, sized to the timer: 10.24 us ost, 2 ms pll lock
`define FCR_OST_CYCLES 18'h00400
`define FCR_PLL_CYCLES 18'h30D40
`define FCR_TMR_WIDTH 18

`endif

/* hdl/fcr_startup_timer.v */
`timescale 1ns/1ps
`include "fcr_regs.vh"

module fcr_startup_timer #(
    parameter [`FCR_TMR_WIDTH-1:0] PLL_CYCLES = `FCR_PLL_CYCLES
)(
    input wire clk_sys,
    input wire sys_rst,
    input wire run,
    input wire osc_ok,
    input wire pll_mode,
    output reg done
);

    localparam [`FCR_TMR_WIDTH-1:0] OST_CYCLES = `FCR_OST_CYCLES;

    reg [`FCR_TMR_WIDTH-1:0] count;
    wire [`FCR_TMR_WIDTH-1:0] target;

    // ost delay, plus lock delay when the pll is used
    assign target = pll_mode ? (OST_CYCLES + PLL_CYCLES) : OST_CYCLES;

    // ----------------------------------------
    // count stable primary cycles
    // ----------------------------------------
    // count restarts whenever the oscillator drops out
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            count <= {`FCR_TMR_WIDTH{1'b0}};
            done <= 1'b0;
        end
        else if (!run || !osc_ok)
        begin
            count <= {`FCR_TMR_WIDTH{1'b0}};
            done <= 1'b0;
        end
        else if (count >= target)
        begin
            done <= 1'b1;
        end
        else
        begin
            count <= count + {{(`FCR_TMR_WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule

/* sim/fcr_properties.sv */
`timescale 1ns/1ps
// ----------------------------------------
// clock control checks
// ----------------------------------------
module fcr_properties (
    input wire clk_sys,
    input wire sys_rst,
    input wire clock_fail,
    input wire sleep_exec,
    input wire wake_irq,
    input wire [1:0] clk_sel,
    input wire failsafe_active,
    input wire monitor_enable,
    input wire pm_active,
    input wire cpu_run,
    input wire irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    chk_fs_hold: assert property (failsafe_active |-> clk_sel == 2'h2)
        else $error("sel left mux");
    chk_fail_set: assert property ($rose(clock_fail) && monitor_enable |-> ##[1:5] failsafe_active)
        else $error("no failsafe");
    chk_fs_exit: assert property ($fell(failsafe_active) |-> $past(sleep_exec))
        else $error("failsafe ended");
    chk_sleep_pm: assert property (sleep_exec && !clock_fail |=> pm_active && monitor_enable && !failsafe_active)
        else $error("sleep ignored");
    chk_ready_mon: assert property ($changed(clk_sel) && clk_sel == 2'h0 |-> monitor_enable)
        else $error("no monitor");
    chk_idle_run: assert property ($fell(cpu_run) |-> $rose(pm_active))
        else $error("cpu halted");
    chk_wake_run: assert property (wake_irq && pm_active && !sleep_exec && !clock_fail |=> !pm_active && cpu_run)
        else $error("no wake");
    chk_dis_stay: assert property ($rose(failsafe_active) && $past(pm_active) && !irq |-> pm_active)
        else $error("pm left");
endmodule
bind fcr_core fcr_properties i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .clock_fail(clock_fail),
    .sleep_exec(sleep_exec), .wake_irq(wake_irq), .clk_sel(clk_sel), .failsafe_active(failsafe_active),
    .monitor_enable(monitor_enable), .pm_active(pm_active), .cpu_run(cpu_run), .irq(irq));

/* sim/fcr_osc_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// primary oscillator model
// ----------------------------------------
module fcr_osc_model (
    input wire clk_sys,
    input wire osc_en,
    input wire osc_kill,
    output wire primary_osc_ok,
    output reg clock_fail
);
    initial clock_fail = 1'b0;
    // failure latches until the oscillator is switched off
    always @(posedge clk_sys)
        clock_fail <= osc_kill | (clock_fail & osc_en);
    assign primary_osc_ok = osc_en & ~clock_fail;
endmodule

/* sim/fcr_core_tb.sv */
`timescale 1ns/1ps
module fcr_core_tb;
    reg clk_sys = 1'b0;
    reg sys_rst = 1'b1;
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_exec = 1'b0, wake_irq = 1'b0;
    reg pll_mode = 1'b1, osc_en = 1'b0, osc_kill = 1'b0, err;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0, rd;
    wire [31:0] prdata;
    wire [1:0] clk_sel;
    wire pready, pslverr, primary_osc_ok, clock_fail, failsafe_active, monitor_enable, pm_active, cpu_run, irq;
    integer errors = 0, total_checks = 0, n, i;
    reg [15:0] rnd = 16'hDE27;
    reg [7:0] ctl;
    reg [1:0] m_sel = 2'h2;
    reg m_fs = 1'b0, m_pm = 1'b0, m_mon = 1'b0, m_run = 1'b1;
    // ----------------------------------------
    // clock, design and oscillator
    // ----------------------------------------
    always #5 clk_sys = ~clk_sys;
    fcr_core #(.PLL_CYCLES(18'd10)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .primary_osc_ok(primary_osc_ok), .clock_fail(clock_fail),
        .pll_mode(pll_mode), .sleep_exec(sleep_exec), .wake_irq(wake_irq), .clk_sel(clk_sel),
        .failsafe_active(failsafe_active), .monitor_enable(monitor_enable), .pm_active(pm_active),
        .cpu_run(cpu_run), .irq(irq));
    fcr_osc_model i_osc (.clk_sys(clk_sys), .osc_en(osc_en), .osc_kill(osc_kill),
        .primary_osc_ok(primary_osc_ok), .clock_fail(clock_fail));
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // expected state word from the model
    function [31:0] st();
        st = {26'h0, m_run, m_pm, m_mon, m_fs, m_sel};
    endfunction
    task finish_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task tmo;
        errors = errors + 1;
        finish_test;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready
    task apb(input w, input [7:0] a, input [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n = n + 1;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            tmo;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input [7:0] a, input [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // bounded wait: primary selected or failsafe set
    task waitc(input k);
        n = 0;
        while (n < 3000 && (k ? failsafe_active !== 1'b1 : clk_sel !== 2'h0))
        begin
            @(posedge clk_sys);
            n = n + 1;
        end
        if (n == 3000)
            tmo;
    endtask
    task pulse(input s);
        @(posedge clk_sys);
        sleep_exec <= s;
        wake_irq <= !s;
        @(posedge clk_sys);
        sleep_exec <= 1'b0;
        wake_irq <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    // restart the oscillator, then make it fail
    task fail;
        @(posedge clk_sys);
        osc_en <= 1'b0;
        @(posedge clk_sys);
        osc_en <= 1'b1;
        osc_kill <= 1'b1;
        @(posedge clk_sys);
        osc_kill <= 1'b0;
        waitc(1'b1);
        repeat (2) @(posedge clk_sys);
        m_fs = 1'b1;
        m_sel = 2'h2;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdchk(8'h10, st());
        apb(1'b1, 8'h00, 32'h01);
        repeat (1100) @(posedge clk_sys);
        rdchk(8'h00, 32'h0);
        rdchk(8'h10, st());
        osc_en <= 1'b1;
        waitc(1'b0);
        chk(n >= 1034 && n <= 1040, 1);
        m_sel = 2'h0;
        m_mon = 1'b1;
        rdchk(8'h10, st());
        rdchk(8'h00, 32'h09);
        rdchk(8'h04, 32'h2);
        apb(1'b1, 8'h08, 32'h2);
        #1 chk(irq, 1);
        apb(1'b1, 8'h08, 32'h0);
        #1 chk(irq, 0);
        apb(1'b1, 8'h0C, 32'h2);
        apb(1'b1, 8'h08, 32'h2);
        #1 chk(irq, 0);
        fail;
        rdchk(8'h10, st());
        rdchk(8'h04, 32'h1);
        rdchk(8'h14, 32'h0);
        chk(err, 1);
        osc_en <= 1'b0;
        repeat (2) @(posedge clk_sys);
        osc_en <= 1'b1;
        repeat (1100) @(posedge clk_sys);
        rdchk(8'h10, st());
        for (i = 0; i < 6; i = i + 1)
        begin
            rnd = lfsr(rnd);
            ctl = {rnd[0], 5'h0, i[1:0]};
            apb(1'b1, 8'h00, {24'h0, ctl});
            pulse(1'b1);
            m_fs = 1'b0;
            m_pm = 1'b1;
            m_run = !ctl[7];
            m_sel = (ctl[1:0] == 2'h3) ? 2'h2 : ctl[1:0];
            rdchk(8'h10, st());
            pulse(1'b0);
            m_pm = 1'b0;
            m_run = 1'b1;
            rdchk(8'h10, st());
        end
        apb(1'b1, 8'h0C, 32'h7);
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b1, 8'h00, 32'h0);
        pulse(1'b1);
        fail;
        rdchk(8'h10, st());
        rdchk(8'h04, 32'h5);
        chk(irq, 1);
        repeat (500) @(posedge clk_sys);
        rdchk(8'h10, st());
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h0C, 32'h7);
        apb(1'b1, 8'h00, 32'h80);
        pulse(1'b1);
        fail;
        m_pm = 1'b1;
        m_run = 1'b0;
        rdchk(8'h10, st());
        rdchk(8'h04, 32'h1);
        pulse(1'b0);
        m_pm = 1'b0;
        m_run = 1'b1;
        rdchk(8'h10, st());
        rdchk(8'h04, 32'h5);
        sys_rst <= 1'b1;
        pll_mode <= 1'b0;
        osc_en <= 1'b0;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        m_sel = 2'h2;
        m_fs = 1'b0;
        m_mon = 1'b0;
        rdchk(8'h10, st());
        // restart without the pll: oscillator delay alone
        osc_en <= 1'b1;
        waitc(1'b0);
        chk(n >= 1024 && n <= 1030, 1);
        m_sel = 2'h0;
        m_mon = 1'b1;
        rdchk(8'h10, st());
        finish_test;
    end
endmodule
